//--- psemc_port.v
// one port's mode sequencer
`include "psemc_defs.vh"
`default_nettype none
module psemc_port #(
  parameter integer BACKOFF_MS     = `PSEMC_BACKOFF_MS,
  parameter integer BACKOFF_MID_MS = `PSEMC_BACKOFF_MID_MS
) (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       ms_tick,
  input  wire [1:0] mode,
  input  wire       auto_ok,
  input  wire       midspan,
  input  wire       det_en,
  input  wire       cls_en,
  input  wire       cmd_detect,
  input  wire       cmd_class,
  input  wire       cmd_on,
  input  wire       cmd_off,
  input  wire       det_done,
  input  wire [2:0] det_result,
  input  wire       cls_done,
  input  wire [2:0] cls_result,
  input  wire       lim_fault,
  input  wire       disc_en,
  input  wire       disc_event,
  input  wire       low_grade,
  input  wire       ext_pwr_ok,
  input  wire [2:0] max_class,
  output reg        det_start,
  output reg        cls_start,
  output wire       two_event,
  output reg        pwr_on_q,
  output reg        start_fault_q,
  output reg  [2:0] det_status_q,
  output reg  [2:0] cls_status_q,
  output reg  [9:0] cut_q,
  output reg  [9:0] lim_q
);
  // *****************************************************
  // state
  // *****************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DET  = 3'h1;
  localparam [2:0] S_CLS  = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  // the first tick can land right after entry, so counting one tick
  // past the backoff keeps the real wait at or above it
  localparam [11:0] WAIT_SHORT = BACKOFF_MS[11:0];
  localparam [11:0] WAIT_LONG  = BACKOFF_MID_MS[11:0];
  reg [2:0]  st_q;
  reg [11:0] wait_q;
  reg        once_q;
  wire shdn  = (mode == `PSEMC_MODE_SHDN);
  wire man   = (mode == `PSEMC_MODE_MANUAL);
  wire autom = (mode == `PSEMC_MODE_AUTO) && auto_ok;
  wire semi  = (mode == `PSEMC_MODE_SEMI) || autom;
  wire good  = (det_status_q == `PSEMC_DET_GOOD);
  // a class-4 answer becomes class 0 on the lowest grade
  wire [2:0] cls_eff = (low_grade && cls_result == 3'h4) ? 3'h0 :
                       cls_result;
  assign two_event = !low_grade;
  always @(posedge sys_clk) begin
    det_start <= 1'b0;
    cls_start <= 1'b0;
    if (!reset_n) begin
      st_q <= S_IDLE;
      wait_q <= 12'h0;
      once_q <= 1'b0;
      pwr_on_q <= 1'b0;
      start_fault_q <= 1'b0;
      det_status_q <= 3'h0;
      cls_status_q <= 3'h0;
      cut_q <= `PSEMC_CUT_C3;
      lim_q <= `PSEMC_LIM_LO;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (man && (cmd_detect || cmd_class)) begin
            once_q <= cmd_class;
            det_start <= 1'b1;
            st_q <= S_DET;
          end else if (semi && det_en) begin
            once_q <= cls_en;
            det_start <= 1'b1;
            st_q <= S_DET;
          end
        end
        S_DET: begin
          if (shdn) begin
            st_q <= S_IDLE;
          end else if (det_done) begin
            det_status_q <= det_result;
            if (det_result == `PSEMC_DET_GOOD && once_q) begin
              cls_start <= 1'b1;
              st_q <= S_CLS;
            end else begin
              if (det_result == `PSEMC_DET_GOOD && !once_q)
                cls_status_q <= `PSEMC_CLASS_FULL;
              st_q <= man ? S_IDLE : S_WAIT;
              wait_q <= 12'h0;
            end
          end
        end
        S_CLS: begin
          if (shdn) begin
            st_q <= S_IDLE;
          end else if (cls_done) begin
            cls_status_q <= cls_eff;
            st_q <= man ? S_IDLE : S_WAIT;
            wait_q <= 12'h0;
          end
        end
        S_WAIT: begin
          // backoff before repeating detection
          if (shdn || man) begin
            st_q <= S_IDLE;
          end else if (ms_tick) begin
            if (wait_q == (midspan ? WAIT_LONG : WAIT_SHORT)) begin
              st_q <= S_IDLE;
            end else begin
              wait_q <= wait_q + 12'h1;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
      // power removal has priority over every turn-on path
      if (shdn || lim_fault || (disc_en && disc_event) || cmd_off) begin
        pwr_on_q <= 1'b0;
      end else if (cmd_on && man) begin
        pwr_on_q <= 1'b1;
      end else if (cmd_on && semi) begin
        if (good && cls_status_q <= max_class)
          pwr_on_q <= 1'b1;
        else
          start_fault_q <= 1'b1;
      end else if (autom && st_q == S_CLS && cls_done &&
                   det_status_q == `PSEMC_DET_GOOD &&
                   cls_eff <= max_class) begin
        pwr_on_q <= 1'b1;
      end else if (autom && st_q == S_DET && det_done && !once_q &&
                   det_result == `PSEMC_DET_GOOD &&
                   `PSEMC_CLASS_FULL <= max_class) begin
        pwr_on_q <= 1'b1;
      end
      if (!semi)
        start_fault_q <= 1'b0;
      if (autom && st_q == S_CLS && cls_done) begin
        case (cls_eff)
          3'h1: cut_q <= `PSEMC_CUT_C1;
          3'h2: cut_q <= `PSEMC_CUT_C2;
          3'h4: cut_q <= `PSEMC_CUT_C4;
          default: cut_q <= `PSEMC_CUT_C3;
        endcase
        lim_q <= (cls_eff == 3'h4) ? `PSEMC_LIM_HI : `PSEMC_LIM_LO;
      end
    end
  end
  wire unused_ok = ext_pwr_ok;
endmodule
`default_nettype wire

//--- psemc_defs.vh
// constants shared by the port mode control block
`ifndef PSEMC_DEFS_VH
`define PSEMC_DEFS_VH
`define PSEMC_MODE_SHDN       2'h0
`define PSEMC_MODE_MANUAL     2'h1
`define PSEMC_MODE_SEMI       2'h2
`define PSEMC_MODE_AUTO       2'h3
`define PSEMC_DET_GOOD        3'h4
`define PSEMC_PWR_38W7        2'h0
`define PSEMC_PWR_52W7        2'h1
`define PSEMC_PWR_70W         2'h2
`define PSEMC_PWR_90W         2'h3
`define PSEMC_CLK_HZ          100000000
`define PSEMC_BACKOFF_MS      100
`define PSEMC_BACKOFF_MID_MS  2000
`define PSEMC_MS_CYCLES       (`PSEMC_CLK_HZ / 1000)
`define PSEMC_CUT_C1          10'h070
`define PSEMC_CUT_C2          10'h0ce
`define PSEMC_CUT_C3          10'h177
`define PSEMC_CUT_C4          10'h27e
`define PSEMC_LIM_LO          10'h1a9
`define PSEMC_LIM_HI          10'h352
`define PSEMC_CLASS_FULL      3'h3
`endif

//--- psemc_ms_tick.v
// millisecond enable pulse divider
`include "psemc_defs.vh"
`default_nettype none
module psemc_ms_tick #(
  parameter integer CYCLES = `PSEMC_MS_CYCLES
) (
  input  wire sys_clk,
  input  wire reset_n,
  output reg  ms_tick
);
  reg [31:0] cnt_q;
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q   <= 32'h0;
      ms_tick <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q   <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      cnt_q   <= cnt_q + 32'h1;
      ms_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- psemc_top.v
// twelve-port operating mode controller
`include "psemc_defs.vh"
`default_nettype none
// Summary of operation
// - twelve ports, four modes by two-bit field
// - manual: one detect/class cycle per command
// - manual: power follows host commands
// - semi-auto: repeat detection, power on command
// - auto: power on after good detect
// - auto loads cut/limit from class
// - auto valid only with strap high
// - shutdown: no detection, no power
// - current-limit fault removes power
// - enabled disconnect event removes power
// - host power-off honoured anytime
// - power-select pins sampled after reset, only with strap high
// - refuse PDs above maximum power
// - extended power needs both enable bits
// - lowest grade: no two-event, class4 as 0
// - skipped class treated as full allocation
// - always high-power mode
// - backoff 100ms, 2s midspan
// - semi-auto power-on needs good detect
module psemc_top #(
  parameter integer PORTS          = 12,
  parameter integer MS_CYCLES      = `PSEMC_MS_CYCLES,
  parameter integer BACKOFF_MS     = `PSEMC_BACKOFF_MS,
  parameter integer BACKOFF_MID_MS = `PSEMC_BACKOFF_MID_MS,
  parameter [1:0]   HOST_MODE      = `PSEMC_MODE_SHDN
) (
  input  wire               sys_clk,
  input  wire               reset_n,
  input  wire               auto_strap,
  input  wire               midspan,
  input  wire               power_select_pin_hi,
  input  wire               power_select_pin_lo,
  input  wire               low_grade,
  input  wire               hp_en,
  input  wire               ext_en,
  input  wire [PORTS-1:0]   mode_wr,
  input  wire [2*PORTS-1:0] mode_wdata,
  input  wire [PORTS-1:0]   det_en,
  input  wire [PORTS-1:0]   cls_en,
  input  wire [PORTS-1:0]   disc_en,
  input  wire [PORTS-1:0]   cmd_detect,
  input  wire [PORTS-1:0]   cmd_class,
  input  wire [PORTS-1:0]   cmd_on,
  input  wire [PORTS-1:0]   cmd_off,
  input  wire [PORTS-1:0]   det_done,
  input  wire [3*PORTS-1:0] det_result,
  input  wire [PORTS-1:0]   cls_done,
  input  wire [3*PORTS-1:0] cls_result,
  input  wire [PORTS-1:0]   lim_fault,
  input  wire [PORTS-1:0]   disc_event,
  output wire [2*PORTS-1:0] port_op_mode_field,
  output wire [PORTS-1:0]   det_start,
  output wire [PORTS-1:0]   cls_start,
  output wire [PORTS-1:0]   two_event,
  output wire [PORTS-1:0]   pwr_on,
  output wire [PORTS-1:0]   start_fault,
  output wire [3*PORTS-1:0] det_status,
  output wire [3*PORTS-1:0] cls_status,
  output wire [10*PORTS-1:0] cut_thr,
  output wire [10*PORTS-1:0] lim_thr,
  output reg  [1:0]         max_power_q,
  output wire               ext_pwr_en
);
  // *****************************************************
  // strap capture
  // *****************************************************
  // straps are caught on the first clock after release, never in reset
  reg             rst_seen_q;
  reg             auto_q;
  reg [2*PORTS-1:0] mode_q;
  integer i;
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      rst_seen_q  <= 1'b0;
      auto_q      <= 1'b0;
      max_power_q <= `PSEMC_PWR_38W7;
      mode_q      <= {2*PORTS{1'b0}};
    end else begin
      rst_seen_q <= 1'b1;
      if (!rst_seen_q) begin
        auto_q <= auto_strap;
        if (auto_strap)
          max_power_q <= {power_select_pin_hi,
                          power_select_pin_lo};
        for (i = 0; i < PORTS; i = i + 1)
          mode_q[2*i +: 2] <= auto_strap ? `PSEMC_MODE_AUTO :
                              HOST_MODE;
      end else begin
        for (i = 0; i < PORTS; i = i + 1)
          if (mode_wr[i])
            mode_q[2*i +: 2] <= mode_wdata[2*i +: 2];
      end
    end
  end
  assign port_op_mode_field = mode_q;
  // auto mode is reserved unless the strap was high at capture and is high now
  wire auto_ok = auto_q && auto_strap;
  // high-power operation is assumed; hp_en only gates the extension
  assign ext_pwr_en = hp_en && ext_en && !low_grade;
  // *****************************************************
  // power cap as a class ceiling
  // *****************************************************
  // only class 0..4 are seen here, so any cap admits class 4, and the
  // ceiling stays class 4 whether extension is on or off
  wire [2:0] max_class = (auto_q || ext_pwr_en) ? 3'h4 :
                         3'h4;
  wire ms_tick;
  psemc_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ms_tick (ms_tick)
  );
  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1) begin : g_port
      psemc_port #(
        .BACKOFF_MS     (BACKOFF_MS),
        .BACKOFF_MID_MS (BACKOFF_MID_MS)
      ) u_port (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .ms_tick       (ms_tick),
        .mode          (mode_q[2*g +: 2]),
        .auto_ok       (auto_ok),
        .midspan       (midspan),
        .det_en        (det_en[g]),
        .cls_en        (cls_en[g]),
        .cmd_detect    (cmd_detect[g]),
        .cmd_class     (cmd_class[g]),
        .cmd_on        (cmd_on[g]),
        .cmd_off       (cmd_off[g]),
        .det_done      (det_done[g]),
        .det_result    (det_result[3*g +: 3]),
        .cls_done      (cls_done[g]),
        .cls_result    (cls_result[3*g +: 3]),
        .lim_fault     (lim_fault[g]),
        .disc_en       (disc_en[g]),
        .disc_event    (disc_event[g]),
        .low_grade     (low_grade),
        .ext_pwr_ok    (ext_pwr_en),
        .max_class     (max_class),
        .det_start     (det_start[g]),
        .cls_start     (cls_start[g]),
        .two_event     (two_event[g]),
        .pwr_on_q      (pwr_on[g]),
        .start_fault_q (start_fault[g]),
        .det_status_q  (det_status[3*g +: 3]),
        .cls_status_q  (cls_status[3*g +: 3]),
        .cut_q         (cut_thr[10*g +: 10]),
        .lim_q         (lim_thr[10*g +: 10])
      );
    end
  endgenerate
endmodule
`default_nettype wire

//--- psemc_top_monitor.sv
// checker for the port mode controller
`default_nettype none
module psemc_top_monitor #(
  parameter integer PORTS = 12
) (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic               low_grade,
  input wire logic               hp_en,
  input wire logic               ext_en,
  input wire logic [PORTS-1:0]   cmd_on,
  input wire logic [PORTS-1:0]   cmd_off,
  input wire logic [PORTS-1:0]   lim_fault,
  input wire logic [PORTS-1:0]   disc_en,
  input wire logic [PORTS-1:0]   disc_event,
  input wire logic [2*PORTS-1:0] port_op_mode_field,
  input wire logic [PORTS-1:0]   det_start,
  input wire logic [PORTS-1:0]   two_event,
  input wire logic [PORTS-1:0]   pwr_on,
  input wire logic [PORTS-1:0]   start_fault,
  input wire logic [1:0]         max_power_q,
  input wire logic               ext_pwr_en
);
  logic [PORTS-1:0] shd;
  logic [PORTS-1:0] on_shd_q;
  genvar g;
  for (g = 0; g < PORTS; g++) begin : g_shd
    assign shd[g] = port_op_mode_field[2*g+:2] == 2'h0;
  end
  always_ff @(posedge sys_clk) begin
    on_shd_q <= cmd_on & shd;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // assertions
  // ****
  a_limit_fault_off:
    assert property (|lim_fault |=> (pwr_on & $past(lim_fault)) == '0)
    else $error("power held after limit fault");
  a_disc_event_off:
    assert property (|(disc_en & disc_event) |=>
      (pwr_on & $past(disc_en) & $past(disc_event)) == '0)
    else $error("power held after disconnect");
  a_host_off:
    assert property (|cmd_off |=> (pwr_on & $past(cmd_off)) == '0)
    else $error("power held after host off");
  a_shutdown_dark:
    assert property (((pwr_on | det_start) & shd & $past(shd, 2)) == '0)
    else $error("shutdown port active");
  a_shdn_on_ignored:
    assert property (|on_shd_q |-> (pwr_on & on_shd_q) == '0)
    else $error("power on taken in shutdown");
  a_no_two_event:
    assert property (two_event == {PORTS{!low_grade}})
    else $error("two-event wrong for grade");
  a_ext_power_gate:
    assert property (ext_pwr_en == (hp_en && ext_en && !low_grade))
    else $error("extended power gate wrong");
  a_power_cap_held:
    assert property ($past(reset_n, 2) |-> $stable(max_power_q))
    else $error("power cap moved after reset");
  a_start_one_cycle:
    assert property (|det_start |=> (det_start & $past(det_start)) == '0)
    else $error("detect start longer than a cycle");
  c_power_on: cover property (|pwr_on);
  c_start_fault: cover property (|start_fault);
  c_detect: cover property (|det_start);
endmodule
bind psemc_top psemc_top_monitor #(.PORTS(PORTS)) u_mon (.*);
`default_nettype wire

//--- psemc_pd_model.sv
// detect and class front end model for the cable side
`default_nettype none
module psemc_pd_model (
  input  wire logic        sys_clk,
  input  wire logic        slow,
  input  wire logic [11:0] det_start,
  input  wire logic [11:0] cls_start,
  input  wire logic [2:0]  res,
  input  wire logic [2:0]  cls,
  output logic      [11:0] det_done,
  output logic      [35:0] det_result,
  output logic      [11:0] cls_done,
  output logic      [35:0] cls_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] d1 = '0, d2 = '0, d3 = '0, c1 = '0, c2 = '0, c3 = '0;
  // ****
  // answer after one or three cycles
  // ****
  always @(posedge sys_clk) begin
    {d3, d2, d1} <= {d2, d1, det_start};
    {c3, c2, c1} <= {c2, c1, cls_start};
  end
  assign det_done = slow ? d3 : d1;
  assign cls_done = slow ? c3 : c1;
  // results are junk outside done, so a stale value never passes
  assign det_result = {12{|det_done ? res : ~res}};
  assign cls_result = {12{|cls_done ? cls : ~cls}};
endmodule
`default_nettype wire

//--- test_psemc_top.sv
// bench for the twelve-port mode controller
`include "psemc_defs.vh"
`default_nettype none
module test_psemc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, reset_n = 1'h0, auto_strap = 1'h0, midspan = 1'h0;
  logic power_select_pin_hi = 1'h0, power_select_pin_lo = 1'h0;
  logic low_grade = 1'h0, hp_en = 1'h1, ext_en = 1'h0, slow = 1'h0;
  logic [11:0] mode_wr = '0, det_en = '0, cls_en = '0, disc_en = '0;
  logic [11:0] cmd_detect = '0, cmd_class = '0, cmd_on = '0, cmd_off = '0;
  logic [11:0] lim_fault = '0, disc_event = '0, det_done, cls_done;
  logic [11:0] det_start, cls_start, two_event, pwr_on, start_fault;
  logic [23:0] mode_wdata = '0, port_op_mode_field;
  logic [35:0] det_result, cls_result, det_status, cls_status;
  logic [119:0] cut_thr, lim_thr;
  logic [1:0]  max_power_q;
  logic        ext_pwr_en;
  logic [2:0]  res = 3'h6, cls = 3'h3;
  int          err_count = 0, n_tests = 0, cyc_n = 0, n0 = 0, nd [12];

  // short backoff so the polling repeats inside a short run
  psemc_top #(.MS_CYCLES(4), .BACKOFF_MS(3), .BACKOFF_MID_MS(6)) uut (.*);
  psemc_pd_model pd (.sys_clk(sys_clk), .slow(slow), .det_start(det_start),
    .cls_start(cls_start), .res(res), .cls(cls), .det_done(det_done),
    .det_result(det_result), .cls_done(cls_done), .cls_result(cls_result));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n++;
    for (int i = 0; i < 12; i++) if (det_start[i]) nd[i]++;
    if (cyc_n == 3000) begin
      err_count++;
      test_done();
    end
  end
  // ****
  // tasks
  // ****
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [9:0] a, input logic [9:0] e);
    n_tests++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  // 0 detect, 1 on, 2 off, 3 limit fault, 4 disconnect, 5 class
  task automatic cmd(input int c, input int p);
    @(posedge sys_clk);
    case (c)
      0: cmd_detect[p] <= 1'h1;
      1: cmd_on[p] <= 1'h1;
      2: cmd_off[p] <= 1'h1;
      3: lim_fault[p] <= 1'h1;
      5: cmd_class[p] <= 1'h1;
      default: disc_event[p] <= 1'h1;
    endcase
    @(posedge sys_clk);
    {cmd_detect, cmd_class, cmd_on, cmd_off, lim_fault, disc_event} <= '0;
    #1;
  endtask
  task automatic setmode(input int p, input logic [1:0] m);
    @(posedge sys_clk);
    mode_wr[p] <= 1'h1;
    mode_wdata[2*p+:2] <= m;
    @(posedge sys_clk);
    mode_wr <= '0;
  endtask
  task automatic rst(input logic [2:0] s);
    @(posedge sys_clk);
    reset_n <= 1'h0;
    {auto_strap, power_select_pin_hi, power_select_pin_lo} <= s;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'h1;
    cyc(2);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    rst(3'h3);
    chk(port_op_mode_field == '0, 1'h1);
    @(posedge sys_clk);
    det_en <= '1;
    cls_en <= 12'hfdf;
    cmd(1, 0);
    setmode(4, 2'h3);
    setmode(1, 2'h1);
    cmd(0, 1);
    cyc(20);
    chk(pwr_on[0], 1'h0);
    chk(nd[0], 0);
    chk(nd[4], 0);
    chk(nd[1], 1);
    chk(det_status[5:3], 3'h6);
    cmd(1, 1);
    chk(pwr_on[1], 1'h1);
    cmd(2, 1);
    chk(pwr_on[1], 1'h0);
    @(posedge sys_clk);
    {res, cls} <= {`PSEMC_DET_GOOD, 3'h1};
    setmode(2, 2'h2);
    setmode(5, 2'h2);
    cmd(5, 1);
    cyc(60);
    chk(nd[2] inside {[2:5]}, 1'h1);
    chk(det_status[8:6], `PSEMC_DET_GOOD);
    chk(cls_status[8:6], 3'h1);
    chk(cls_status[5:3], 3'h1);
    chk(cls_status[17:15], `PSEMC_CLASS_FULL);
    chk(pwr_on[2], 1'h0);
    chk(cut_thr[29:20], `PSEMC_CUT_C3);
    cmd(1, 2);
    chk(pwr_on[2], 1'h1);
    cmd(3, 2);
    chk(pwr_on[2], 1'h0);
    cmd(1, 2);
    chk(pwr_on[2], 1'h1);
    cmd(4, 2);
    chk(pwr_on[2], 1'h1);
    @(posedge sys_clk);
    disc_en <= '1;
    cmd(4, 2);
    chk(pwr_on[2], 1'h0);
    @(posedge sys_clk);
    res <= 3'h3;
    setmode(3, 2'h2);
    cyc(30);
    cmd(1, 3);
    chk(start_fault[3], 1'h1);
    chk(pwr_on[3], 1'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {low_grade, hp_en, ext_en} <= 3'(i);
      cyc(1);
      chk(ext_pwr_en, i == 3);
      chk(two_event == {12{i < 4}}, 1'h1);
    end
    // lowest grade still set: class 4 must read back as 0, slow polling
    n0 = nd[2];
    @(posedge sys_clk);
    {res, cls, midspan} <= {`PSEMC_DET_GOOD, 3'h4, 1'h1};
    cyc(100);
    chk(nd[2] - n0 inside {[2:4]}, 1'h1);
    chk(cls_status[8:6], 3'h0);
    @(posedge sys_clk);
    {low_grade, hp_en, ext_en, slow} <= 4'h7;
    {res, cls} <= {`PSEMC_DET_GOOD, 3'h1};
    rst(3'h6);
    chk(max_power_q, `PSEMC_PWR_70W);
    chk(port_op_mode_field[1:0], `PSEMC_MODE_AUTO);
    cyc(40);
    chk(pwr_on[0], 1'h1);
    chk(cut_thr[9:0], `PSEMC_CUT_C1);
    chk(lim_thr[9:0], `PSEMC_LIM_LO);
    test_done();
  end
endmodule
`default_nettype wire
